// >>> rtl/pbm_pkg.sv
// Package for the program memory bank mapper: constants, field layouts and carrier types
`default_nettype none
package pbm_pkg;
   localparam logic [7:0] PBM_BANK_SEL_ADDR = 8'hB1;
   localparam logic [7:0] PBM_BANK_SEL_RESET = 8'h11;
   localparam logic [7:0] PBM_BANK_SEL_MASK = 8'h33;
   localparam int PBM_FETCH_LSB = 0;
   localparam int PBM_CONST_LSB = 4;
   localparam logic [7:0] PBM_DIRECT_SPLIT = 8'h80;
   localparam logic [16:0] PBM_RESERVED_BASE = 17'h1FC00;
   localparam logic [7:0] PBM_OPC_SPARE = 8'hA5;
   localparam int PBM_ADDR_W = 17;

   typedef enum logic [1:0] {
      PBM_ACC_FETCH = 2'b00,
      PBM_ACC_CONST = 2'b01,
      PBM_ACC_WRITE = 2'b10,
      PBM_ACC_NONE = 2'b11
   } pbm_acc_e;

   typedef enum logic [1:0] {
      PBM_BR_REL = 2'b00,
      PBM_BR_PAGE = 2'b01,
      PBM_BR_FAR = 2'b10,
      PBM_BR_NONE = 2'b11
   } pbm_br_e;

   typedef struct packed {
      pbm_acc_e kind;
      logic scratch;
      logic [15:0] addr;
   } pbm_code_req_s;

   typedef struct packed {
      logic valid;
      logic [16:0] addr;
      logic write_ok;
      logic reserved;
   } pbm_code_map_s;

   typedef struct packed {
      pbm_code_map_s map;
      logic [1:0] const_bank;
      logic [1:0] fetch_bank;
   } pbm_state_s;
endpackage
`default_nettype wire

// >>> rtl/pbm_branch_calc.sv
// Branch target formation for relative, page and far forms
`default_nettype none
module pbm_branch_calc
   import pbm_pkg::*;
(
   input wire pbm_br_e form,
   input wire logic [15:0] next_pc,
   input wire logic [15:0] operand,
   output logic [15:0] target
);
   always_comb begin
      case (form)
         // Sign-extended displacement from the following instruction
         PBM_BR_REL: target = next_pc + {{8{operand[7]}}, operand[7:0]};
         PBM_BR_PAGE: target = {next_pc[15:11], operand[10:0]};
         PBM_BR_FAR: target = operand;
         default: target = next_pc;
      endcase
   end
endmodule
`default_nettype wire

// >>> rtl/pbm_mapper.sv
// Program memory bank mapper with its bank select register and operand routing
`default_nettype none
module pbm_mapper
   import pbm_pkg::*;
#(
   parameter bit BANKED = 1'b1
)
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   input wire pbm_code_req_s code_req,
   input wire logic program_store_control_wen,
   output pbm_code_map_s code_map,
   input wire logic direct_valid,
   input wire logic direct_indirect,
   input wire logic [7:0] direct_addr,
   output logic data_ram_sel,
   output logic sfr_space_sel,
   input wire logic [7:0] opcode,
   output logic opcode_is_nop,
   input wire pbm_br_e branch_form,
   input wire logic [15:0] next_pc,
   input wire logic [15:0] branch_operand,
   output logic [15:0] branch_target
);
   pbm_state_s st;
   pbm_state_s next_st;
   logic reg_hit;
   logic [1:0] sel_bank;
   logic [16:0] lin;
   pbm_code_map_s next_map;

   if (PBM_ADDR_W != 17) begin : g_width_check
      $error("Address width must hold 128 kB");
   end

   // The page register is not consulted, so the register answers on every page
   assign reg_hit = sfr_addr == PBM_BANK_SEL_ADDR;

   always_comb begin
      next_st = st;
      next_st.map = next_map;
      if (srst) begin
         next_st.fetch_bank = PBM_BANK_SEL_RESET[1:0];
         next_st.const_bank = PBM_BANK_SEL_RESET[5:4];
         next_st.map = '0;
      end else if (sfr_wr && reg_hit) begin
         next_st.fetch_bank = sfr_wdata[PBM_FETCH_LSB+:2];
         next_st.const_bank = sfr_wdata[PBM_CONST_LSB+:2];
      end
   end

   always_ff @(posedge sys_clk) begin
      st <= next_st;
   end

   // Reserved bits read back as zero
   always_comb begin
      sfr_rdata = '0;
      if (sfr_rd && reg_hit) begin
         sfr_rdata[PBM_FETCH_LSB+:2] = st.fetch_bank;
         sfr_rdata[PBM_CONST_LSB+:2] = st.const_bank;
      end
   end
   assign sfr_hit = reg_hit;

   // Bank choice for the upper window; constants on scratchpad skip the field
   always_comb begin
      case (code_req.kind)
         PBM_ACC_FETCH: sel_bank = st.fetch_bank;
         PBM_ACC_CONST, PBM_ACC_WRITE: sel_bank = code_req.scratch ? 2'b00 : st.const_bank;
         default: sel_bank = 2'b00;
      endcase
   end

   always_comb begin
      if (!BANKED) begin
         lin = {1'b0, code_req.addr};
      end else if (!code_req.addr[15]) begin
         lin = {2'b00, code_req.addr[14:0]};
      end else begin
         lin = {sel_bank, code_req.addr[14:0]};
      end
   end

   always_comb begin
      next_map = '0;
      if (code_req.kind != PBM_ACC_NONE) begin
         next_map.valid = 1'b1;
         next_map.addr = lin;
         // Reserved top of bank three refuses every access not flagged scratch
         next_map.reserved = BANKED && !code_req.scratch && lin >= PBM_RESERVED_BASE;
         next_map.write_ok = code_req.kind == PBM_ACC_WRITE && program_store_control_wen
            && !next_map.reserved;
         if (next_map.reserved) next_map.valid = 1'b0;
      end
   end

   // Registered so the flash sees a stable address; one cycle of latency
   // The map rides in the state struct, so it shares the one register stage
   assign code_map = st.map;

   // Direct operands at or above the split reach special registers; indirect ones never do
   function automatic logic is_sfr_space(input logic indirect, input logic [7:0] addr);
      return !indirect && addr >= PBM_DIRECT_SPLIT;
   endfunction

   always_comb begin
      data_ram_sel = direct_valid && !is_sfr_space(direct_indirect, direct_addr);
      sfr_space_sel = direct_valid && is_sfr_space(direct_indirect, direct_addr);
   end

   assign opcode_is_nop = opcode == 8'h00 || opcode == PBM_OPC_SPARE;

   pbm_branch_calc u_branch (
      .form(branch_form),
      .next_pc(next_pc),
      .operand(branch_operand),
      .target(branch_target)
   );

   a_reset_banks: assert property (@(posedge sys_clk)
      srst |=> st.fetch_bank == 2'b01 && st.const_bank == 2'b01)
      else $error("bank fields not 01 after reset");
   a_low_window: assert property (@(posedge sys_clk) disable iff (srst)
      BANKED && code_req.kind != PBM_ACC_NONE && !code_req.addr[15]
      |=> code_map.addr[16:15] == 2'b00)
      else $error("low window not bank zero");
   a_fetch_bank: assert property (@(posedge sys_clk) disable iff (srst)
      BANKED && code_req.kind == PBM_ACC_FETCH && code_req.addr[15]
      |=> code_map.addr[16:15] == $past(st.fetch_bank))
      else $error("fetch bank wrong");
   a_write_gate: assert property (@(posedge sys_clk) disable iff (srst)
      code_map.write_ok |-> $past(program_store_control_wen))
      else $error("write without enable");
   a_reserved_top: assert property (@(posedge sys_clk) disable iff (srst)
      code_map.valid && BANKED |-> code_map.addr < PBM_RESERVED_BASE || $past(code_req.scratch))
      else $error("reserved area reached");
   a_direct_split: assert property (@(posedge sys_clk) disable iff (srst)
      !(data_ram_sel && sfr_space_sel))
      else $error("both spaces selected");
   a_reg_write: assert property (@(posedge sys_clk) disable iff (srst)
      sfr_wr && reg_hit |=> st.const_bank == $past(sfr_wdata[5:4]))
      else $error("constant bank not written");
   a_spare_nop: assert property (@(posedge sys_clk) disable iff (srst)
      opcode == PBM_OPC_SPARE |-> opcode_is_nop)
      else $error("spare opcode not nop");

   // Upper-window requests, then their answer one edge later
   sequence s_const_upper;
      BANKED && (code_req.kind == PBM_ACC_CONST || code_req.kind == PBM_ACC_WRITE)
         && code_req.addr[15] && !code_req.scratch;
   endsequence
   sequence s_const_answer;
      ##1 code_map.addr[16:15] == $past(st.const_bank);
   endsequence
   sequence s_scratch_upper;
      BANKED && code_req.kind != PBM_ACC_NONE && code_req.kind != PBM_ACC_FETCH
         && code_req.addr[15] && code_req.scratch;
   endsequence
   sequence s_scratch_answer;
      ##1 code_map.addr[16:15] == 2'b00 && !code_map.reserved;
   endsequence

   a_const_bank: assert property (@(posedge sys_clk) disable iff (srst)
      s_const_upper |-> s_const_answer)
      else $error("constant bank wrong");
   a_scratch_bank: assert property (@(posedge sys_clk) disable iff (srst)
      s_scratch_upper |-> s_scratch_answer)
      else $error("scratch access used the bank field");

   // Code map answers, checked one edge after the request
   a_upper_offset: assert property (@(posedge sys_clk) disable iff (srst)
      code_req.kind != PBM_ACC_NONE
      |=> code_map.addr[14:0] == $past(code_req.addr[14:0]))
      else $error("window offset not kept");
   a_flat_map: assert property (@(posedge sys_clk) disable iff (srst)
      !BANKED && code_req.kind != PBM_ACC_NONE
      |=> code_map.valid && code_map.addr == {1'b0, $past(code_req.addr)})
      else $error("flat map not linear");
   a_idle_map: assert property (@(posedge sys_clk) disable iff (srst)
      code_req.kind == PBM_ACC_NONE
      |=> !code_map.valid && !code_map.write_ok)
      else $error("idle cycle produced an access");
   a_read_only: assert property (@(posedge sys_clk) disable iff (srst)
      code_req.kind != PBM_ACC_WRITE
      |=> !code_map.write_ok)
      else $error("non-write access enabled a write");
   a_write_enable: assert property (@(posedge sys_clk) disable iff (srst)
      code_req.kind == PBM_ACC_WRITE && program_store_control_wen && !code_req.addr[15]
      |=> code_map.write_ok)
      else $error("enabled write refused");
   a_write_reserved: assert property (@(posedge sys_clk) disable iff (srst)
      code_map.reserved |-> !code_map.valid && !code_map.write_ok)
      else $error("reserved area accepted");
   // No disable here: reset itself is the trigger
   a_reset_map: assert property (@(posedge sys_clk)
      srst |=> code_map == '0)
      else $error("code map not cleared by reset");

   // Register read-back and operand decode
   a_reg_reserved: assert property (@(posedge sys_clk) disable iff (srst)
      (sfr_rdata & ~PBM_BANK_SEL_MASK) == 8'h00)
      else $error("reserved bank select bits not zero");
   a_indirect_ram: assert property (@(posedge sys_clk) disable iff (srst)
      direct_valid && direct_indirect |-> data_ram_sel && !sfr_space_sel)
      else $error("indirect operand left data RAM");

   // Branch forms
   a_rel_target: assert property (@(posedge sys_clk) disable iff (srst)
      branch_form == PBM_BR_REL
      |-> 16'(branch_target - next_pc) == {{8{branch_operand[7]}}, branch_operand[7:0]})
      else $error("relative target wrong");
   a_page_target: assert property (@(posedge sys_clk) disable iff (srst)
      branch_form == PBM_BR_PAGE |-> branch_target[15:11] == next_pc[15:11])
      else $error("page target left its page");
   a_far_target: assert property (@(posedge sys_clk) disable iff (srst)
      branch_form == PBM_BR_FAR |-> branch_target == branch_operand)
      else $error("far target not the operand");
endmodule
`default_nettype wire

// >>> tb/pbm_core_model.sv
// Core-side model driving code requests and the store write enable
`default_nettype none
module pbm_core_model
   import pbm_pkg::*;
(
   input wire logic sys_clk,
   output pbm_code_req_s req,
   output logic wen
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {req, wen} = {PBM_ACC_NONE, 18'h00000};
   // Enable is set with the request, never after it
   task automatic issue(input pbm_acc_e k, input logic s, input logic [15:0] a, input logic w);
      wen = w;
      req = '{k, s, a};
      @(posedge sys_clk);
      #1;
   endtask
endmodule
`default_nettype wire

// >>> tb/pbm_mapper_tb_top.sv
// Self-checking bench for the program memory bank mapper
`default_nettype none
module pbm_mapper_tb_top
   import pbm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, srst = 1'b1, wr = 1'b0, dv = 1'b0, di = 1'b0, nop, ram, sfs, hit, w;
   logic rd = 1'b1;
   logic [7:0] sa = 8'hB1, sd = 8'h00, rdat, da = 8'h00, opc = 8'h00;
   logic [15:0] npc = 16'h0000, bop = 16'h0000, tgt, et;
   logic [1:0] fb, cb;
   pbm_br_e bf = PBM_BR_NONE;
   pbm_code_req_s req;
   pbm_code_map_s map, fmap, m, m2, q[$], q2[$];
   int failures = 0, compares = 0, cyc = 0, due[$];
   pbm_mapper dut_u (.sys_clk(sys_clk), .srst(srst), .sfr_wr(wr), .sfr_rd(rd),
      .sfr_addr(sa), .sfr_wdata(sd), .sfr_rdata(rdat), .sfr_hit(hit), .code_req(req),
      .program_store_control_wen(w), .code_map(map), .direct_valid(dv),
      .direct_indirect(di), .direct_addr(da), .data_ram_sel(ram), .sfr_space_sel(sfs),
      .opcode(opc), .opcode_is_nop(nop), .branch_form(bf), .next_pc(npc),
      .branch_operand(bop), .branch_target(tgt));
   pbm_core_model core_u (.sys_clk(sys_clk), .req(req), .wen(w));
   pbm_mapper #(.BANKED(1'b0)) flat_u (.sys_clk(sys_clk), .srst(srst), .sfr_wr(wr), .sfr_rd(rd),
      .sfr_addr(sa), .sfr_wdata(sd), .sfr_rdata(), .sfr_hit(), .code_req(req),
      .program_store_control_wen(w), .code_map(fmap), .direct_valid(dv),
      .direct_indirect(di), .direct_addr(da), .data_ram_sel(), .sfr_space_sel(),
      .opcode(opc), .opcode_is_nop(), .branch_form(bf), .next_pc(npc),
      .branch_operand(bop), .branch_target());
   initial forever #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) cyc <= cyc + 1;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic sel(input logic [7:0] d);
      sd = d;
      wr = 1'b1;
      @(posedge sys_clk);
      #1;
      wr = 1'b0;
      {cb, fb} = {d[5:4], d[1:0]};
      chk("bank_sel", d & 8'h33, rdat);
   endtask
   // Map notes are due one cycle after the request is taken
   task automatic rq(input pbm_acc_e k, input logic s, input logic [15:0] a, input logic x);
      m.addr = {(a[15] && !s) ? (k == PBM_ACC_FETCH ? fb : cb) : 2'b00, a[14:0]};
      m.reserved = !s && m.addr >= 17'h1FC00;
      m.valid = !m.reserved;
      m.write_ok = m.valid && k == PBM_ACC_WRITE && x;
      q.push_back(m);
      m2 = '{1'b1, {1'b0, a}, k == PBM_ACC_WRITE && x, 1'b0};
      q2.push_back(m2);
      due.push_back(cyc + 1);
      core_u.issue(k, s, a, x);
   endtask
   always @(posedge sys_clk) begin
      #2;
      if (due.size() > 0 && due[0] == cyc) begin
         void'(due.pop_front());
         chk("code_map", {q[0][19:0] & {1'b1, {17{q[0].valid}}, 2'b11}},
            {map & {1'b1, {17{map.valid}}, 2'b11}});
         void'(q.pop_front());
         chk("flat_map", q2[0], fmap);
         void'(q2.pop_front());
      end
   end
   initial begin
      void'($urandom(32'hFD2B));
      repeat (4) @(posedge sys_clk);
      #1;
      srst = 1'b0;
      chk("bank_sel", 8'h11, rdat);
      chk("map_reset", 32'h0, map);
      sa = 8'hB2;
      @(posedge sys_clk);
      #1;
      chk("unmapped", 9'h000, {hit, rdat});
      sa = 8'hB1;
      rd = 1'b0;
      @(posedge sys_clk);
      #1;
      chk("no_read", 9'h100, {hit, rdat});
      rd = 1'b1;
      for (int i = 0; i < 40; i++) begin
         sel(8'($urandom()));
         rq(pbm_acc_e'(i % 3), 1'b0, 16'($urandom()), 1'($urandom()));
         rq(PBM_ACC_CONST, 1'b1, 16'h8000 | 16'($urandom()), 1'b0);
      end
      sel(8'hFF);
      rq(PBM_ACC_FETCH, 1'b0, 16'hFBFF, 1'b0);
      rq(PBM_ACC_WRITE, 1'b0, 16'hFC00, 1'b1);
      core_u.issue(PBM_ACC_NONE, 1'b0, 16'h0000, 1'b0);
      srst = 1'b1;
      @(posedge sys_clk);
      #1;
      srst = 1'b0;
      {cb, fb} = 4'h5;
      chk("bank_sel", 8'h11, rdat);
      chk("map_reset", 32'h0, map);
      for (int i = 0; i < 64; i++) begin
         {da, di, dv, npc, bop} = {8'($urandom()), 2'($urandom()), 32'($urandom())};
         opc = i[1] ? 8'($urandom()) : (i[0] ? 8'hA5 : 8'h00);
         bf = pbm_br_e'(i % 4);
         et = bf == PBM_BR_FAR ? bop : (bf == PBM_BR_PAGE ? {npc[15:11], bop[10:0]} : npc);
         if (bf == PBM_BR_REL) et = npc + {{8{bop[7]}}, bop[7:0]};
         #1;
         chk("ram_sel", dv && (di || !da[7]), ram);
         chk("sfr_sel", dv && !di && da[7], sfs);
         chk("nop", opc == 8'h00 || opc == 8'hA5, nop);
         chk("target", et, tgt);
         @(posedge sys_clk);
      end
      summarize();
   end
   initial begin
      #20000;
      failures++;
      summarize();
   end
   task automatic summarize();
      failures += q.size() + q2.size();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
endmodule
`default_nettype wire
